/* File: capture_compare_map.vh */
// Register map, field positions and mode codes of the capture/compare unit
// What this block does, and what software must do
// (RL1) Value word is two byte registers
// (RL2) Special event clears whole Timer1 count
// (RL3) Mode 0000 disables and resets unit
// (RL4) Capture modes select falling/rising/4th/16th edge
// (RL5) Compare 1000 sets, 1001 clears output
// (RL6) Compare 1010 sets flag, pin untouched
// (RL7) Compare 1011 resets Timer1, starts conversion
// (RL8) 11xx selects PWM with ten duty bits
// (RL9) Capture copies Timer1 count into value
// (RL10) Capture sets flag; only software clears
// (RL11) New capture overwrites unread earlier value
// (RL12) Capture watches pin level even when output
// (RL13) Software keeps Timer1 synchronous while capturing
// (RL14) Software masks enable around capture mode change
// (RL15) Prescaler cleared when off, non-capture, reset
// (RL16) Capture-to-capture change keeps prescaler count
// (RL17) Software writes zero before new prescale
// (RL18) Compare value continuously against Timer1 count
// (RL19) Special event never sets overflow flag
// (RL20) Zero control forces compare latch low
// (RL21) Pin synchronized; each edge counted once
`ifndef CAPTURE_COMPARE_MAP_VH
`define CAPTURE_COMPARE_MAP_VH

`define IDX_FLAGS 8'h0c
`define IDX_VALUE_LOW 8'h13
`define IDX_VALUE_HIGH 8'h14
`define IDX_CONTROL 8'h15
`define IDX_ENABLES 8'h8c

`define SEL_NONE 3'h0
`define SEL_FLAGS 3'h1
`define SEL_VALUE_LOW 3'h2
`define SEL_VALUE_HIGH 3'h3
`define SEL_CONTROL 3'h4
`define SEL_ENABLES 3'h5

`define FLAG_UNIT_BIT 5
`define FLAG_OVF_BIT 0
`define FLAGS_IMPL_MASK 8'h21
`define ENABLES_IMPL_MASK 8'hef
`define CONTROL_IMPL_MASK 8'h3f
`define CTRL_MODE_HI 3
`define CTRL_MODE_LO 0
`define CTRL_DUTY_HI 5
`define CTRL_DUTY_LO 4

`define MODE_OFF 4'h0
`define MODE_CAP_FALL 4'h4
`define MODE_CAP_RISE 4'h5
`define MODE_CAP_RISE4 4'h6
`define MODE_CAP_RISE16 4'h7
`define MODE_CMP_SET 4'h8
`define MODE_CMP_CLEAR 4'h9
`define MODE_CMP_SOFT 4'ha
`define MODE_CMP_SPECIAL 4'hb
`define MODE_GROUP_CAPTURE 2'h1
`define MODE_GROUP_COMPARE 2'h2
`define MODE_GROUP_PWM 2'h3

`define PRESCALE_LAST4 4'h3
`define PRESCALE_LAST16 4'hf
`define RESET_BYTE 8'h00
`define RESET_WORD 16'h0000
`define SYNC_STAGES 3

`endif

/* File: pin_sync.v */
// Three-stage synchroniser with agreement filter for the event pin
`timescale 1ns/10ps
`include "capture_compare_map.vh"
module pin_sync (
  input wire core_clk,
  input wire srst,
  input wire pinIn,
  output reg pinLevel_q
);
  reg [`SYNC_STAGES-1:0] stage_q;
  wire [`SYNC_STAGES-1:0] chainIn;

  // Input of each stage, so no stage indexes below the chain
  assign chainIn = {stage_q[`SYNC_STAGES-2:0], pinIn};

  // Stage 0 feeds only stage 1; the filter looks at stages 1 and 2
  genvar i;
  generate
    for (i = 0; i < `SYNC_STAGES; i = i + 1) begin : chain
      always @(posedge core_clk) begin
        if (srst) begin
          stage_q[i] <= 1'b0;
        end else begin
          stage_q[i] <= chainIn[i];
        end
      end
    end
  endgenerate

  always @(posedge core_clk) begin
    if (srst) begin
      pinLevel_q <= 1'b0;
    end else if (stage_q[1] == stage_q[2]) begin
      pinLevel_q <= stage_q[2]; // RL21
    end
  end
endmodule

/* File: capture_compare_unit.v */
// Capture/compare unit with APB register access
//
// Implementation choice: register access over APB.
`timescale 1ns/10ps
`include "capture_compare_map.vh"
module capture_compare_unit (
  input wire core_clk,
  input wire srst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire sharedEventPin,
  input wire [15:0] counterValue,
  input wire counterOverflow,
  input wire converterEnabled,
  output reg compareOut_q,
  output reg counterClear_q,
  output reg conversionStart_q,
  output reg pwmSelect_q,
  output reg [9:0] dutyCycle_q
);
  reg [7:0] flags_q;
  reg [7:0] enables_q;
  reg [7:0] control_q;
  reg [7:0] valueLow_q;
  reg [7:0] valueHigh_q;
  reg [3:0] prescale_q;
  reg pinPrev_q;
  reg matchPrev_q;
  wire pinLevel;
  wire [3:0] mode;
  wire [1:0] modeGroup;
  wire isCapture;
  wire isCompare;
  wire riseEdge;
  wire fallEdge;
  wire [15:0] matchValueWord;
  wire matchNow;
  wire matchEvent;
  wire accessDone;
  wire writeDone;
  wire [2:0] sel;
  reg captureEvent;
  reg [3:0] prescale_d;

  // Decodes a byte address to a register select; unmapped gives none
  function [2:0] regSelect;
    input [11:0] addr;
    begin
      if (addr[1:0] != 2'b00 || addr[11:10] != 2'b00) begin
        regSelect = `SEL_NONE;
      end else begin
        case (addr[9:2])
          `IDX_FLAGS: regSelect = `SEL_FLAGS;
          `IDX_VALUE_LOW: regSelect = `SEL_VALUE_LOW;
          `IDX_VALUE_HIGH: regSelect = `SEL_VALUE_HIGH;
          `IDX_CONTROL: regSelect = `SEL_CONTROL;
          `IDX_ENABLES: regSelect = `SEL_ENABLES;
          default: regSelect = `SEL_NONE;
        endcase
      end
    end
  endfunction

  pin_sync u_pin_sync (
    .core_clk(core_clk),
    .srst(srst),
    .pinIn(sharedEventPin),
    .pinLevel_q(pinLevel)
  );

  assign mode = control_q[`CTRL_MODE_HI:`CTRL_MODE_LO];
  assign modeGroup = mode[3:2];
  assign isCapture = (modeGroup == `MODE_GROUP_CAPTURE);
  assign isCompare = (modeGroup == `MODE_GROUP_COMPARE);
  assign matchValueWord = {valueHigh_q, valueLow_q}; // RL1

  // Pin level is watched regardless of the port direction
  assign riseEdge = pinLevel & ~pinPrev_q; // RL12 RL21
  assign fallEdge = ~pinLevel & pinPrev_q; // RL12 RL21

  // Only the first cycle of equality counts, so a stalled counter
  // does not retrigger the action every clock
  assign matchNow = (matchValueWord == counterValue); // RL18
  assign matchEvent = isCompare & matchNow & ~matchPrev_q; // RL18

  assign sel = regSelect(paddr);
  assign accessDone = psel & penable & pready;
  assign writeDone = accessDone & pwrite & (sel != `SEL_NONE);

  // Event selection and prescaler; count survives capture-to-capture
  // changes because only leaving the capture group clears it
  always @* begin
    captureEvent = 1'b0;
    prescale_d = prescale_q;
    if (!isCapture) begin
      prescale_d = 4'h0; // RL15 RL3
    end else begin
      case (mode) // RL4 RL16
        `MODE_CAP_FALL: captureEvent = fallEdge;
        `MODE_CAP_RISE: captureEvent = riseEdge;
        `MODE_CAP_RISE4: begin
          if (riseEdge) begin
            if (prescale_q[1:0] == `PRESCALE_LAST4) begin
              captureEvent = 1'b1;
              prescale_d = 4'h0;
            end else begin
              prescale_d = prescale_q + 4'h1;
            end
          end
        end
        `MODE_CAP_RISE16: begin
          if (riseEdge) begin
            if (prescale_q == `PRESCALE_LAST16) begin
              captureEvent = 1'b1;
              prescale_d = 4'h0;
            end else begin
              prescale_d = prescale_q + 4'h1;
            end
          end
        end
        default: captureEvent = 1'b0;
      endcase
    end
  end

  always @(posedge core_clk) begin
    if (srst) begin
      prescale_q <= 4'h0; // RL15
      pinPrev_q <= 1'b0;
      matchPrev_q <= 1'b0;
    end else begin
      prescale_q <= prescale_d;
      pinPrev_q <= pinLevel;
      matchPrev_q <= isCompare & matchNow;
    end
  end

  // Control register; bits 7-6 are unimplemented and read zero
  always @(posedge core_clk) begin
    if (srst) begin
      control_q <= `RESET_BYTE;
    end else if (writeDone && sel == `SEL_CONTROL) begin
      control_q <= pwdata[7:0] & `CONTROL_IMPL_MASK;
    end
  end

  always @(posedge core_clk) begin
    if (srst) begin
      enables_q <= `RESET_BYTE;
    end else if (writeDone && sel == `SEL_ENABLES) begin
      enables_q <= pwdata[7:0] & `ENABLES_IMPL_MASK;
    end
  end

  // Value bytes: a capture takes priority over a software write in
  // the same cycle, and always overwrites an unread value
  always @(posedge core_clk) begin
    if (srst) begin
      valueLow_q <= `RESET_BYTE;
      valueHigh_q <= `RESET_BYTE;
    end else if (captureEvent) begin
      valueLow_q <= counterValue[7:0]; // RL9 RL11
      valueHigh_q <= counterValue[15:8]; // RL9 RL11
    end else if (writeDone) begin
      if (sel == `SEL_VALUE_LOW) begin
        valueLow_q <= pwdata[7:0];
      end
      if (sel == `SEL_VALUE_HIGH) begin
        valueHigh_q <= pwdata[7:0];
      end
    end
  end

  // Flags: software clears by writing zero, hardware set wins
  always @(posedge core_clk) begin
    if (srst) begin
      flags_q <= `RESET_BYTE;
    end else begin
      if (writeDone && sel == `SEL_FLAGS) begin
        flags_q <= pwdata[7:0] & `FLAGS_IMPL_MASK;
      end
      if (captureEvent) begin
        flags_q[`FLAG_UNIT_BIT] <= 1'b1; // RL10
      end
      if (matchEvent) begin
        flags_q[`FLAG_UNIT_BIT] <= 1'b1; // RL5 RL6 RL7
      end
      // The special event clear is not an overflow
      if (counterOverflow) begin
        flags_q[`FLAG_OVF_BIT] <= 1'b1; // RL19
      end
    end
  end

  // Compare output latch
  always @(posedge core_clk) begin
    if (srst) begin
      compareOut_q <= 1'b0;
    end else if (mode == `MODE_OFF) begin
      compareOut_q <= 1'b0; // RL20 RL3
    end else if (matchEvent) begin
      case (mode)
        `MODE_CMP_SET: compareOut_q <= 1'b1; // RL5
        `MODE_CMP_CLEAR: compareOut_q <= 1'b0; // RL5
        default: compareOut_q <= compareOut_q; // RL6 RL7
      endcase
    end
  end

  // Special event: one-cycle pulses to the counter and converter
  always @(posedge core_clk) begin
    if (srst) begin
      counterClear_q <= 1'b0;
      conversionStart_q <= 1'b0;
    end else begin
      counterClear_q <= matchEvent & (mode == `MODE_CMP_SPECIAL); // RL2 RL7
      conversionStart_q <= matchEvent & (mode == `MODE_CMP_SPECIAL) &
        converterEnabled; // RL7
    end
  end

  // PWM selection and duty word; the period machinery sits elsewhere
  always @(posedge core_clk) begin
    if (srst) begin
      pwmSelect_q <= 1'b0;
      dutyCycle_q <= 10'h000;
    end else begin
      pwmSelect_q <= (modeGroup == `MODE_GROUP_PWM); // RL8
      dutyCycle_q <= {valueLow_q,
        control_q[`CTRL_DUTY_HI:`CTRL_DUTY_LO]}; // RL8
    end
  end

  // APB slave: one wait state, so every access takes three cycles
  always @(posedge core_clk) begin
    if (srst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= (sel == `SEL_NONE);
      prdata <= 32'h00000000;
      if (!pwrite) begin
        case (sel)
          `SEL_FLAGS: prdata[7:0] <= flags_q;
          `SEL_VALUE_LOW: prdata[7:0] <= valueLow_q;
          `SEL_VALUE_HIGH: prdata[7:0] <= valueHigh_q;
          `SEL_CONTROL: prdata[7:0] <= control_q;
          `SEL_ENABLES: prdata[7:0] <= enables_q;
          default: prdata <= 32'h00000000;
        endcase
      end
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end
endmodule

/* File: cc_far_side.sv */
// Far-side model: event pin and a Timer1 counter on the core clock
`timescale 1ns/10ps
module cc_far_side (
  input wire core_clk,
  input wire run,
  input wire load,
  input wire [15:0] loadVal,
  input wire pinDrive,
  input wire counterClear_q,
  output reg [15:0] counterValue = 16'h0000,
  output reg counterOverflow = 1'b0,
  output wire sharedEventPin
);
  assign sharedEventPin = pinDrive;
  // Counting only on core_clk keeps the count synchronous to the unit
  always @(posedge core_clk) begin
    counterOverflow <= run && !load && counterValue == 16'hffff;
    if (load)
      counterValue <= loadVal;
    else if (counterClear_q)
      counterValue <= 16'h0000;
    else if (run)
      counterValue <= counterValue + 16'h0001;
  end
endmodule

/* File: capture_compare_unit_sva.sv */
// Port assertions for the capture/compare unit
`timescale 1ns/10ps
module capture_compare_unit_sva (
  input wire core_clk,
  input wire srst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire converterEnabled,
  input wire compareOut_q,
  input wire counterClear_q,
  input wire conversionStart_q,
  input wire pwmSelect_q
);
  reg [5:0] ctrl_q;
  wire [3:0] mode = ctrl_q[3:0];
  wire pwmMode = ctrl_q[3] & ctrl_q[2];
  // Shadow of the mode bits, taken at the committing edge
  always @(posedge core_clk)
    if (srst)
      ctrl_q <= 6'h00;
    else if (psel && penable && pready && pwrite && paddr == 12'h054)
      ctrl_q <= pwdata[5:0];
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence setupPh;
    psel && !penable;
  endsequence
  sequence answer;
    !pready ##1 pready;
  endsequence
  apb_latency_a: assert property (setupPh |=> answer)
    else $error("late bus answer");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready too long");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  rdata_high_a: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("read data high bits");
  set_rise_a: assert property (
    $rose(compareOut_q) |-> $past(mode) == 4'h8) else $error("bad rise");
  clear_fall_a: assert property (
    $fell(compareOut_q) |-> $past(mode) inside {4'h0, 4'h9} || mode == 4'h0)
    else $error("bad fall");
  pin_hold_a: assert property (
    mode[3:1] == 3'b101 |=> $stable(compareOut_q)) else $error("pin moved");
  special_mode_a: assert property (
    counterClear_q |-> $past(mode) == 4'hb) else $error("stray clear");
  clear_pulse_a: assert property (counterClear_q |=> !counterClear_q)
    else $error("clear too long");
  conv_gate_a: assert property (
    conversionStart_q |-> counterClear_q && $past(converterEnabled))
    else $error("stray conversion");
  pwm_select_a: assert property (pwmSelect_q == $past(pwmMode))
    else $error("pwm select");
endmodule
bind capture_compare_unit capture_compare_unit_sva u_sva (.*);

/* File: capture_compare_unit_tb.sv */
// Self-checking bench for the capture/compare unit
`timescale 1ns/10ps
module capture_compare_unit_tb;
  reg core_clk = 1'b0, srst = 1'b1;
  reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  reg run = 1'b0, load = 1'b0, pinDrive = 1'b0, convEn = 1'b0;
  reg [15:0] loadVal = 16'h0000, v;
  reg [7:0] d;
  reg [8:0] q[$];
  wire [31:0] prdata;
  wire pready, pslverr, evPin, ovf, cmpOut, clr, conv, pwmSel;
  wire [15:0] cnt;
  wire [9:0] duty;
  int fails = 0, compares = 0, clrs = 0, convs = 0, i, m, n;
  capture_compare_unit u_dut (.core_clk(core_clk), .srst(srst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sharedEventPin(evPin), .counterValue(cnt), .counterOverflow(ovf),
    .converterEnabled(convEn), .compareOut_q(cmpOut),
    .counterClear_q(clr), .conversionStart_q(conv),
    .pwmSelect_q(pwmSel), .dutyCycle_q(duty));
  cc_far_side u_far (.core_clk(core_clk), .run(run), .load(load),
    .loadVal(loadVal), .pinDrive(pinDrive), .counterClear_q(clr),
    .counterValue(cnt), .counterOverflow(ovf), .sharedEventPin(evPin));
  initial forever #12.5 core_clk = ~core_clk;
  task automatic chk(input [15:0] got, input [15:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    if (fails == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Bus answers are matched against the oldest noted expectation
  always @(posedge core_clk) begin
    clrs += clr;
    convs += conv;
    if (pready)
      chk({7'h0, pslverr, pwrite ? 8'h00 : prdata[7:0]}, {7'h0, q.pop_front()});
  end
  task automatic xfer(input w, input [11:0] a, input [7:0] dt, input [8:0] ex);
    q.push_back(ex);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, dt};
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk iff pready);
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge, so a following call never re-drives psel in this step
    @(posedge core_clk);
  endtask
  task automatic wr(input [11:0] a, input [7:0] dt);
    xfer(1'b1, a, dt, 9'h000);
  endtask
  task automatic rd(input [11:0] a, input [7:0] ex);
    xfer(1'b0, a, 8'h00, {1'b0, ex});
  endtask
  task automatic mode(input [7:0] md);
    wr(12'h054, md);
    wr(12'h030, 8'h00);
  endtask
  task automatic setCnt(input [15:0] val);
    loadVal <= val;
    load <= 1'b1;
    @(posedge core_clk);
    load <= 1'b0;
  endtask
  // The count differs at the rising and falling pin edges
  task automatic pulse(input [15:0] val);
    setCnt(val);
    pinDrive <= 1'b1;
    repeat (8) @(posedge core_clk);
    setCnt(~val);
    pinDrive <= 1'b0;
    repeat (8) @(posedge core_clk);
  endtask
  task automatic capt(input [15:0] val);
    rd(12'h030, 8'h20);
    rd(12'h04c, val[7:0]);
    rd(12'h050, val[15:8]);
    wr(12'h030, 8'h00);
  endtask
  task automatic cmp(input [7:0] md, input ex);
    mode(md);
    setCnt(v - 16'h000c);
    run <= 1'b1;
    repeat (24) @(posedge core_clk);
    run <= 1'b0;
    chk({15'h0, cmpOut}, {15'h0, ex});
    rd(12'h030, 8'h20);
  endtask
  initial begin
    v = $urandom(32'h16b86a8e);
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    rd(12'h030, 8'h00);
    rd(12'h04c, 8'h00);
    rd(12'h050, 8'h00);
    rd(12'h054, 8'h00);
    rd(12'h230, 8'h00);
    xfer(1'b0, 12'h040, 8'h00, 9'h100);
    wr(12'h230, 8'hff);
    rd(12'h230, 8'hef);
    wr(12'h230, 8'h00);
    wr(12'h054, 8'hff);
    rd(12'h054, 8'h3f);
    for (m = 4; m < 6; m++) begin
      mode(m[7:0]);
      v = 16'($urandom);
      pulse(v ^ 16'h5a5a);
      pulse(v);
      capt(m == 4 ? ~v : v);
    end
    mode(8'h06);
    pulse(16'h0001);
    pulse(16'h0002);
    for (m = 6; m < 8; m++) begin
      mode(8'h00);
      mode(m[7:0]);
      n = m == 6 ? 4 : 16;
      for (i = 1; i < n; i++)
        pulse(v);
      rd(12'h030, 8'h00);
      v = 16'($urandom);
      pulse(v);
      capt(v);
    end
    v = {8'h01, 8'($urandom)};
    wr(12'h04c, v[7:0]);
    wr(12'h050, v[15:8]);
    cmp(8'h08, 1'b1);
    cmp(8'h0a, 1'b1);
    mode(8'h00);
    chk({15'h0, cmpOut}, 16'h0000);
    cmp(8'h08, 1'b1);
    cmp(8'h09, 1'b0);
    for (i = 1; i >= 0; i--) begin
      convEn <= i[0];
      m = clrs;
      n = convs;
      cmp(8'h0b, 1'b0);
      chk(16'(clrs - m), 16'h0001);
      chk(16'(convs - n), 16'(i));
    end
    mode(8'h00);
    setCnt(16'hfffe);
    run <= 1'b1;
    repeat (4) @(posedge core_clk);
    run <= 1'b0;
    rd(12'h030, 8'h01);
    d = 8'($urandom);
    wr(12'h04c, d);
    wr(12'h054, 8'h2c);
    repeat (2) @(posedge core_clk);
    chk({5'h0, pwmSel, duty}, {5'h0, 1'b1, d, 2'b10});
    mode(8'h00);
    report_and_stop;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    report_and_stop;
  end
endmodule
